/* File: rtl/padc_pkg.sv */
package padc_pkg;
  // register select field on the data bus
  localparam int SEL_MSB = 7;
  localparam int SEL_LSB = 6;
  localparam logic [1:0] SEL_CONV = 2'h0;
  localparam logic [1:0] SEL_FMT = 2'h1;
  // conversion control field positions
  localparam int START_MODE_POS = 5;
  localparam int PWR_DOWN_POS = 4;
  localparam int CLOCK_SOURCE_POS = 3;
  localparam int DONE_MODE_POS = 2;
  // format control field positions
  localparam int OSC_SPEED_POS = 4;
  localparam int OUTPUT_FORMAT_POS = 1;
  // values after reset and after hardware configuration
  localparam logic [5:0] CONV_RESET = 6'h00;
  localparam logic [5:0] FMT_RESET = 6'h00;
  // sequencing counts in core clock cycles, power-down count in reference cycles, clock rates in MHz
  localparam int SAMPLE_CYCLES = 6;
  localparam int CONVERT_CYCLES = 10;
  localparam int TOTAL_CYCLES = SAMPLE_CYCLES + CONVERT_CYCLES;
  localparam int SOFT_PD_CYCLES = 2;
  localparam int OSC_SLOW_MHZ = 10;
  localparam int OSC_FAST_MHZ = 20;
  localparam int REF_MHZ = 25;
  // sequencer states
  typedef enum logic [2:0] {
    PADC_IDLE, PADC_SAMPLE, PADC_CONVERT, PADC_DONE, PADC_AUTO_PD
  } padc_state_e;
  // strobes after synchronising
  typedef struct packed {
    logic csN;
    logic rdN;
    logic wrN;
    logic startN;
  } padc_pins_s;
endpackage : padc_pkg

/* File: rtl/padc_ctrl.sv */
`timescale 1ns/1ps
// Behaviour
// - sixteen core clocks per software-started sample and conversion
// - bits seven and six pick register
// - each write replaces whole register
// - write held low plus read loads zeros
// - software: write rise first, read rise after
// - software sampling lasts six core clocks
// - conversion lasts ten core clocks after sampling
// - hardware sampling lasts while strobe low
// - one interrupt pulse per conversion
// - end-of-conversion low during conversion
// - result valid from interrupt rising edge
// - no read next cycle: auto power-down
// - chip select high: deep power-down, keep registers
// - code saturates at both references
// - internal clock starts on trigger edge
// - clock source bit selects oscillator or external
// - oscillator speed bit picks 10 or 20
// - format bit selects binary or twos complement
// - data captured on write rise, select low
module padc_ctrl #(
  parameter int DATA_W = 8
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic csN,
  input wire logic rdN,
  input wire logic wrN,
  input wire logic hwStartStrobeN,
  input wire logic extClk,
  input wire logic [DATA_W-1:0] dataIn,
  input wire logic compareHigh,
  output logic [DATA_W-1:0] dataOut,
  output logic dataOe,
  output logic doneN,
  output logic sampleHold,
  output logic [DATA_W-1:0] dacCode,
  output logic comparatorOn,
  output logic softPowerDown,
  output logic autoPowerDown
);
  // three-stage synchronisers for the host strobes and the external clock
  padc_pkg::padc_pins_s pinS1, pinS2, pinS3;
  logic extS1, extS2, extS3;
  logic [DATA_W-1:0] dataS1, dataS2, dataS3;
  // agreed levels, moved only when stages two and three match
  padc_pkg::padc_pins_s pinA;
  logic extA;
  // registers and sequencer
  logic [5:0] conversion_control_reg;
  logic [5:0] format_control_reg;
  padc_pkg::padc_state_e state_reg;
  logic [3:0] cycleCnt_reg;
  logic [DATA_W-1:0] sar_reg;
  logic [DATA_W-1:0] result_reg;
  logic [DATA_W-1:0] bitMask_reg;
  logic firstStart_reg;
  logic [4:0] oscAcc_reg;
  logic [1:0] softPdCnt_reg;
  // decoded strobes from agreeing second and third stages, plus coreTick, which comes from the oscillator when the internal clock is used
  logic wrRise, rdRise, rdFall, stFall, stRise, extRise, coreTick;
  logic startMode, useExt, doneIsEoc;

  // stage one feeds stage two only; stage three is the agreement stage
  // the data bus gets three stages too, so it stays aligned with the
  // write strobe edge that is reported in the same cycle that stage three changes
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pinS1 <= '1;
      pinS2 <= '1;
      pinS3 <= '1;
      extS1 <= 1'b0;
      extS2 <= 1'b0;
      extS3 <= 1'b0;
      dataS1 <= '0;
      dataS2 <= '0;
      dataS3 <= '0;
    end else begin
      pinS1 <= '{csN: csN, rdN: rdN, wrN: wrN, startN: hwStartStrobeN};
      pinS2 <= pinS1;
      pinS3 <= pinS2;
      extS1 <= extClk;
      extS2 <= extS1;
      extS3 <= extS2;
      dataS1 <= dataIn;
      dataS2 <= dataS1;
      dataS3 <= dataS2;
    end
  end

  // agreed levels: a change counts only once stages two and three agree,
  // so a first stage that settled late can never give a double edge
  // strobes idle high after reset, so no false edge follows release
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pinA <= '1;
      extA <= 1'b0;
    end else begin
      // chip select level
      if (pinS2.csN == pinS3.csN) begin
        pinA.csN <= pinS3.csN;
      end
      // read strobe level
      if (pinS2.rdN == pinS3.rdN) begin
        pinA.rdN <= pinS3.rdN;
      end
      // write strobe level
      if (pinS2.wrN == pinS3.wrN) begin
        pinA.wrN <= pinS3.wrN;
      end
      // hardware start strobe level
      if (pinS2.startN == pinS3.startN) begin
        pinA.startN <= pinS3.startN;
      end
      // external core clock level
      if (extS2 == extS3) begin
        extA <= extS3;
      end
    end
  end

  // rising edge: late stages agree high, agreed copy still low
  function automatic logic riseOf(input logic s2, input logic s3, input logic agreed);
    riseOf = (s2 == s3) && s3 && !agreed;
  endfunction : riseOf

  // falling edge: late stages agree low, agreed copy still high
  function automatic logic fallOf(input logic s2, input logic s3, input logic agreed);
    fallOf = (s2 == s3) && !s3 && agreed;
  endfunction : fallOf

  // edges last exactly one cycle, as the agreed copy follows next edge
  // host strobes count only while chip select is agreed low
  assign wrRise = riseOf(pinS2.wrN, pinS3.wrN, pinA.wrN) && !pinA.csN;
  assign rdRise = riseOf(pinS2.rdN, pinS3.rdN, pinA.rdN) && !pinA.csN;
  assign rdFall = fallOf(pinS2.rdN, pinS3.rdN, pinA.rdN) && !pinA.csN;
  assign stFall = fallOf(pinS2.startN, pinS3.startN, pinA.startN);
  assign stRise = riseOf(pinS2.startN, pinS3.startN, pinA.startN);
  assign extRise = riseOf(extS2, extS3, extA);
  assign startMode = conversion_control_reg[padc_pkg::START_MODE_POS];
  assign useExt = conversion_control_reg[padc_pkg::CLOCK_SOURCE_POS];
  assign doneIsEoc = conversion_control_reg[padc_pkg::DONE_MODE_POS];

  // internal oscillator as a phase accumulator on ref_clk; it restarts
  // on every trigger so the first tick lands a full period later
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      oscAcc_reg <= '0;
    end else if (state_reg == padc_pkg::PADC_IDLE || state_reg == padc_pkg::PADC_AUTO_PD) begin
      oscAcc_reg <= '0;
    end else if (coreTick) begin
      oscAcc_reg <= oscAcc_reg + oscStep() - 5'(padc_pkg::REF_MHZ);
    end else begin
      oscAcc_reg <= oscAcc_reg + oscStep();
    end
  end

  // step size from the oscillator speed bit
  function automatic logic [4:0] oscStep();
    oscStep = format_control_reg[padc_pkg::OSC_SPEED_POS]
      ? 5'(padc_pkg::OSC_FAST_MHZ) : 5'(padc_pkg::OSC_SLOW_MHZ);
  endfunction : oscStep

  // core clock enable: external edge or oscillator wrap
  always_comb begin
    if (useExt) begin
      coreTick = extRise;
    end else begin
      coreTick = ({1'b0, oscAcc_reg} + {1'b0, oscStep()}) >= 6'(padc_pkg::REF_MHZ);
    end
  end

  // register writes; hardware configuration when write stays low
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      conversion_control_reg <= padc_pkg::CONV_RESET;
      format_control_reg <= padc_pkg::FMT_RESET;
    end else if (rdFall && !pinS3.wrN) begin
      // write seen low in the same stage as the read fall, so a write
      // tied low and a dummy read together give the default setup
      conversion_control_reg <= padc_pkg::CONV_RESET;
      format_control_reg <= padc_pkg::FMT_RESET;
    end else if (wrRise) begin
      // whole six bits replaced, no masking
      // select codes two and three address nothing and are dropped
      if (dataS3[padc_pkg::SEL_MSB:padc_pkg::SEL_LSB] == padc_pkg::SEL_CONV) begin
        conversion_control_reg <= dataS3[5:0];
      end else if (dataS3[padc_pkg::SEL_MSB:padc_pkg::SEL_LSB] == padc_pkg::SEL_FMT) begin
        format_control_reg <= dataS3[5:0];
      end
    end
  end

  // sequencer: sample, convert ten ticks, then done and power-down
  // the mode bit is read as it stood before the current write lands, so
  // the write that selects software start only configures; the next
  // write rising edge starts the first sampling period
  // limitation: a read rise before that first write is ignored, and a
  // chip select excursion rearms the first-start write
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state_reg <= padc_pkg::PADC_IDLE;
      cycleCnt_reg <= '0;
      firstStart_reg <= 1'b1;
    end else if (pinA.csN) begin
      // deep power-down holds the sequencer, registers kept
      state_reg <= padc_pkg::PADC_IDLE;
      cycleCnt_reg <= '0;
      firstStart_reg <= 1'b1;
    end else begin
      case (state_reg)
        padc_pkg::PADC_IDLE, padc_pkg::PADC_AUTO_PD: begin
          if (!startMode && stFall) begin
            state_reg <= padc_pkg::PADC_SAMPLE;
            cycleCnt_reg <= '0;
          end else if (startMode && ((firstStart_reg && wrRise) || (!firstStart_reg && rdRise))) begin
            state_reg <= padc_pkg::PADC_SAMPLE;
            firstStart_reg <= 1'b0;
            cycleCnt_reg <= '0;
          end
        end
        padc_pkg::PADC_SAMPLE: begin
          if (!startMode) begin
            if (stRise) begin
              state_reg <= padc_pkg::PADC_CONVERT;
              cycleCnt_reg <= '0;
            end
          end else if (coreTick) begin
            if (cycleCnt_reg == 4'(padc_pkg::SAMPLE_CYCLES - 1)) begin
              state_reg <= padc_pkg::PADC_CONVERT;
              cycleCnt_reg <= '0;
            end else begin
              cycleCnt_reg <= cycleCnt_reg + 4'h1;
            end
          end
        end
        padc_pkg::PADC_CONVERT: begin
          if (coreTick) begin
            if (cycleCnt_reg == 4'(padc_pkg::CONVERT_CYCLES - 1)) begin
              state_reg <= padc_pkg::PADC_DONE;
              cycleCnt_reg <= '0;
            end else begin
              cycleCnt_reg <= cycleCnt_reg + 4'h1;
            end
          end
        end
        default: begin
          // one core clock window to see a read
          if (rdFall) begin
            state_reg <= padc_pkg::PADC_IDLE;
          end else if (coreTick) begin
            state_reg <= padc_pkg::PADC_AUTO_PD;
          end
        end
      endcase
    end
  end

  // successive approximation, one bit per tick for the first eight ticks
  // the trial code output is loaded in the same edge as the trial
  // register, so the comparator already sees the new trial when core
  // ticks fall on consecutive reference cycles (fast oscillator)
  // the last two ticks of the ten only pad the conversion time
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      sar_reg <= '0;
      dacCode <= '0;
      bitMask_reg <= '0;
      result_reg <= '0;
    end else if (state_reg == padc_pkg::PADC_SAMPLE) begin
      // trial starts at mid-scale
      sar_reg <= {1'b1, {(DATA_W-1){1'b0}}};
      dacCode <= {1'b1, {(DATA_W-1){1'b0}}};
      bitMask_reg <= {1'b1, {(DATA_W-1){1'b0}}};
    end else if (state_reg == padc_pkg::PADC_CONVERT && coreTick) begin
      if (bitMask_reg != '0) begin
        // comparator high keeps the bit; all ones or all zeros saturate
        sar_reg <= (compareHigh ? sar_reg : (sar_reg & ~bitMask_reg)) | (bitMask_reg >> 1);
        dacCode <= (compareHigh ? sar_reg : (sar_reg & ~bitMask_reg)) | (bitMask_reg >> 1);
        bitMask_reg <= bitMask_reg >> 1;
      end
      if (cycleCnt_reg == 4'(padc_pkg::CONVERT_CYCLES - 1)) begin
        // result latched before done so it is valid at the done edge
        result_reg <= format_control_reg[padc_pkg::OUTPUT_FORMAT_POS]
          ? (sar_reg ^ {1'b1, {(DATA_W-1){1'b0}}}) : sar_reg;
      end
    end
  end

  // done line, read bus and power flags
  // every output is a flop, so each one trails the state by one cycle;
  // the host sees done and the bus enable one reference cycle late
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      doneN <= 1'b1;
      dataOut <= '0;
      dataOe <= 1'b0;
      sampleHold <= 1'b0;
      comparatorOn <= 1'b0;
      autoPowerDown <= 1'b0;
      softPowerDown <= 1'b0;
      softPdCnt_reg <= '0;
    end else begin
      if (doneIsEoc) begin
        doneN <= (state_reg != padc_pkg::PADC_CONVERT);
      end else begin
        // low for the done state only: one pulse, rising edge marks data
        doneN <= (state_reg != padc_pkg::PADC_DONE);
      end
      dataOut <= result_reg;
      // bus driven only in a read with write high, never during setup
      dataOe <= !pinA.csN && !pinA.rdN && pinA.wrN;
      sampleHold <= (state_reg == padc_pkg::PADC_SAMPLE);
      comparatorOn <= !pinA.csN && (state_reg == padc_pkg::PADC_CONVERT);
      autoPowerDown <= (state_reg == padc_pkg::PADC_AUTO_PD);
      // deep power-down after chip select high; host honours minimum times
      // the counter saturates so the flag stays up for any long deselect
      if (!pinA.csN) begin
        softPdCnt_reg <= '0;
        softPowerDown <= 1'b0;
      end else if (softPdCnt_reg != 2'(padc_pkg::SOFT_PD_CYCLES)) begin
        softPdCnt_reg <= softPdCnt_reg + 2'h1;
        softPowerDown <= 1'b1;
      end
    end
  end
endmodule : padc_ctrl

/* File: bench/padc_comp_model.sv */
`timescale 1ns/1ps
// analog side: comparator against the trial code
module padc_comp_model (
  input int analogIn,
  input wire logic [7:0] dacCode,
  output logic compareHigh
);
  // levels past either reference keep or drop every bit
  assign compareHigh = analogIn >= int'(dacCode);
endmodule : padc_comp_model

/* File: bench/padc_ctrl_checker.sv */
`timescale 1ns/1ps
// watches the host pins of the converter control
module padc_ctrl_checker #(
  parameter int DATA_W = 8
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic csN,
  input wire logic rdN,
  input wire logic wrN,
  input wire logic hwStartStrobeN,
  input wire logic extClk,
  input wire logic [DATA_W-1:0] dataIn,
  input wire logic compareHigh,
  input wire logic [DATA_W-1:0] dataOut,
  input wire logic dataOe,
  input wire logic doneN,
  input wire logic sampleHold,
  input wire logic [DATA_W-1:0] dacCode,
  input wire logic comparatorOn,
  input wire logic softPowerDown,
  input wire logic autoPowerDown
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // eight cycles cover the three-flop synchroniser, the agreement flop and the output flop
  property p_cs_release; csN [*8] |-> !dataOe; endproperty
  a_cs_release: assert property (p_cs_release) else $error("bus driven while deselected");
  property p_rd_release; rdN [*8] |-> !dataOe; endproperty
  a_rd_release: assert property (p_rd_release) else $error("bus driven without read");
  property p_spd_on; csN [*8] |-> softPowerDown; endproperty
  a_spd_on: assert property (p_spd_on) else $error("no power-down with select high");
  property p_spd_off; !csN [*8] |-> !softPowerDown; endproperty
  a_spd_off: assert property (p_spd_off) else $error("power-down with select low");
  property p_conv_len; $rose(comparatorOn) |-> comparatorOn [*8]; endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion cut short");
  property p_done_back; $fell(doneN) |-> ##[1:200] doneN; endproperty
  a_done_back: assert property (p_done_back) else $error("done stuck low");
  property p_data_hold; dataOe && $past(dataOe) |-> $stable(dataOut); endproperty
  a_data_hold: assert property (p_data_hold) else $error("result moved mid-read");
  property p_apd_idle; sampleHold |-> !autoPowerDown; endproperty
  a_apd_idle: assert property (p_apd_idle) else $error("sampling while powered down");
  property p_rst_done; disable iff (1'b0) !rst_b |=> doneN; endproperty
  a_rst_done: assert property (p_rst_done) else $error("done low after reset");
  c_done: cover property ($fell(doneN));
  c_read: cover property ($rose(dataOe));
  c_apd: cover property ($rose(autoPowerDown));
endmodule : padc_ctrl_checker
bind padc_ctrl padc_ctrl_checker #(.DATA_W(DATA_W)) padc_ctrl_checker_i (.*);

/* File: bench/padc_ctrl_tb_top.sv */
`timescale 1ns/1ps
module padc_ctrl_tb_top;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic csN = 1'b0, rdN = 1'b1, wrN = 1'b1, hwStartStrobeN = 1'b1, extClk = 1'b0;
  logic [7:0] dataIn = 8'h00;
  logic [7:0] dataOut, dacCode, e;
  logic compareHigh, dataOe, doneN, sampleHold, comparatorOn, softPowerDown, autoPowerDown;
  logic [31:0] seed = 32'hC804EE69;
  logic [1:0] divCnt = 2'h0;
  int analogIn = 0;
  int mismatches = 0;
  int compares = 0;
  int n;
  always #20 ref_clk = ~ref_clk;
  // external core clock at a quarter of the reference
  always @(posedge ref_clk) begin
    divCnt <= divCnt + 2'h1;
    extClk <= divCnt[1];
  end
  padc_ctrl padc_ctrl_i (.ref_clk(ref_clk), .rst_b(rst_b), .csN(csN), .rdN(rdN), .wrN(wrN),
    .hwStartStrobeN(hwStartStrobeN), .extClk(extClk), .dataIn(dataIn),
    .compareHigh(compareHigh), .dataOut(dataOut), .dataOe(dataOe), .doneN(doneN),
    .sampleHold(sampleHold), .dacCode(dacCode), .comparatorOn(comparatorOn),
    .softPowerDown(softPowerDown), .autoPowerDown(autoPowerDown));
  padc_comp_model padc_comp_model_i (.analogIn(analogIn), .dacCode(dacCode),
    .compareHigh(compareHigh));
  task automatic tick(int k);
    repeat (k) @(posedge ref_clk);
  endtask : tick
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  task automatic chk(string nm, logic [7:0] ex, logic [7:0] got);
    compares++;
    if (got !== ex) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  // reference model: clip to the references, msb flipped for twos complement
  function automatic logic [7:0] model(int v, bit tc);
    int s;
    s = v < 0 ? 0 : (v > 255 ? 255 : v);
    return 8'(s) ^ (tc ? 8'h80 : 8'h00);
  endfunction : model
  // one step of the bench's shift register
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // random level, some beyond either reference
  task automatic newLevel();
    seed = lfsr(seed);
    analogIn = int'(seed[8:0]) - 128;
  endtask : newLevel
  // ends three cycles after the write rising edge
  task automatic wr(logic [7:0] d);
    dataIn <= d;
    wrN <= 1'b0;
    tick(4);
    wrN <= 1'b1;
    tick(3);
  endtask : wr
  task automatic rd(logic [7:0] ex);
    rdN <= 1'b0;
    tick(8);
    chk("dataOe", 8'h01, {7'h00, dataOe});
    chk("dataOut", ex, dataOut);
    rdN <= 1'b1;
    tick(2);
  endtask : rd
  // bounded wait for done low then high again
  task automatic waitDone(output int c);
    c = 0;
    while (doneN !== 1'b0 && c < 2000) begin tick(1); c++; end
    while (doneN !== 1'b1 && c < 2000) begin tick(1); c++; end
    chk("doneTimeout", 8'h01, {7'h00, c < 2000});
  endtask : waitDone
  initial begin
    tick(60000);
    mismatches++;
    give_verdict();
  end
  initial begin
    tick(12);
    rst_b <= 1'b1;
    tick(4);
    // write held low with a dummy read gives hardware start
    wrN <= 1'b0;
    rdN <= 1'b0;
    tick(6);
    rdN <= 1'b1;
    tick(6);
    wrN <= 1'b1;
    tick(6);
    newLevel();
    hwStartStrobeN <= 1'b0;
    tick(30);
    chk("sampleHold", 8'h01, {7'h00, sampleHold});
    hwStartStrobeN <= 1'b1;
    waitDone(n);
    rd(model(analogIn, 1'b0));
    $display("test hardware start done");
    // software start, external clock, eoc, twos complement
    wr(8'h42);
    newLevel();
    wr(8'h2C);
    wr(8'h2C);
    waitDone(n);
    chk("span", 8'h01, {7'h00, n >= 60 && n <= 80});
    for (int i = 0; i < 3; i++) begin
      e = model(analogIn, 1'b1);
      newLevel();
      rd(e);
      waitDone(n);
    end
    $display("test software start done");
    // internal fast oscillator, interrupt mode, binary again
    wr(8'h50);
    wr(8'h20);
    e = model(analogIn, 1'b1);
    newLevel();
    rd(e);
    waitDone(n);
    tick(12);
    chk("autoPowerDown", 8'h01, {7'h00, autoPowerDown});
    rd(model(analogIn, 1'b0));
    csN <= 1'b1;
    tick(10);
    chk("softPowerDown", 8'h01, {7'h00, softPowerDown});
    csN <= 1'b0;
    tick(10);
    rd(model(analogIn, 1'b0));
    wr(8'h20);
    waitDone(n);
    $display("test power down done");
    // unused select ignored, then back to hardware start
    wr(8'h00);
    wr(8'hE0);
    newLevel();
    hwStartStrobeN <= 1'b0;
    tick(4);
    hwStartStrobeN <= 1'b1;
    waitDone(n);
    rd(model(analogIn, 1'b0));
    $display("test select done");
    give_verdict();
  end
endmodule : padc_ctrl_tb_top
